// [logic/dcsil_map.svh]
// constants of the distributed-clock sync and input latch block
`ifndef DCSIL_MAP_SVH
`define DCSIL_MAP_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DCSIL_MCLK_PERIOD_NS 10
// local clock advance per rising mclk edge, equal to the period above
`define DCSIL_DC_STEP_NS     64'h0000_0000_0000_000A

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define DCSIL_TIME_W         64
`define DCSIL_PERIOD_W       32
`define DCSIL_EVT_W          8
`define DCSIL_TIME_RST       64'h0000_0000_0000_0000
`define DCSIL_SHIFT_ZERO     64'h0000_0000_0000_0000

// ---------------------------------------------------------------
// event byte codes, only bits 2..0 carry information
// ---------------------------------------------------------------
`define DCSIL_EVT_USED_MSB   2
`define DCSIL_EVT_NONE       8'h00
`define DCSIL_EVT2_RISE      8'h01
`define DCSIL_EVT2_FALL      8'h02
`define DCSIL_EVT4_HIGH      8'h04
`define DCSIL_EVT4_RISE      8'h05

`endif

// [logic/dcsil_pkg.sv]
// types of the distributed-clock sync and input latch block
package dcsil_pkg;

  // sync unit control states
  typedef enum logic [1:0] {
    DCSIL_SU_OFF,
    DCSIL_SU_WAIT,
    DCSIL_SU_RUN
  } dcsil_state_type;

  typedef logic [63:0] dcsil_time_type;
  typedef logic [7:0]  dcsil_evt_type;

endpackage : dcsil_pkg

// [logic/dcsil_chan_if.sv]
// per-channel carrier between the sync unit and an edge latch
`timescale 1ns/1ns
interface dcsil_chan_if;
  import dcsil_pkg::*;
  logic           level_in;
  dcsil_time_type dc_time;
  logic           one_shot;
  logic           four_chan;
  logic           last_edge;
  logic           frame_arrive;
  logic           rise_read;
  logic           fall_read;
  dcsil_time_type rise_stamp;
  dcsil_time_type fall_stamp;
  dcsil_evt_type  event_byte;
  logic           level_snap;

  modport chan (
    input  level_in, dc_time, one_shot, four_chan, last_edge,
    input  frame_arrive, rise_read, fall_read,
    output rise_stamp, fall_stamp, event_byte, level_snap
  );
  modport top (
    output level_in, dc_time, one_shot, four_chan, last_edge,
    output frame_arrive, rise_read, fall_read,
    input  rise_stamp, fall_stamp, event_byte, level_snap
  );
endinterface : dcsil_chan_if

// [logic/dcsil_edge_chan.sv]
// edge timestamp latch and event byte of one input channel
`timescale 1ns/1ns
`include "dcsil_map.svh"
module dcsil_edge_chan
  import dcsil_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // channel carrier
  dcsil_chan_if.chan ch
);

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic           lvl_prev_reg;
  logic           prime_reg;
  logic           rise_edge;
  logic           fall_edge;
  logic           rise_seen_reg;
  logic           fall_seen_reg;
  logic           rise_pend_reg;
  logic           fall_pend_reg;
  dcsil_time_type rise_stamp_reg;
  dcsil_time_type fall_stamp_reg;
  dcsil_evt_type  event_reg;
  dcsil_evt_type  event_next;
  logic           level_snap_reg;

  // no edge until the pin level has been seen once after reset
  assign rise_edge = prime_reg & ch.level_in & ~lvl_prev_reg;
  assign fall_edge = prime_reg & ~ch.level_in & lvl_prev_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lvl_prev_reg <= 1'b0;
    else        lvl_prev_reg <= ch.level_in;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) prime_reg <= 1'b0;
    else        prime_reg <= 1'b1;
  end

  // ---------------------------------------------------------------
  // timestamps, always live; frame arrival only restarts the first-edge window
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_seen_reg <= 1'b0;
      fall_seen_reg <= 1'b0;
    end else begin
      if (rise_edge)             rise_seen_reg <= 1'b1;
      else if (ch.frame_arrive)  rise_seen_reg <= 1'b0;
      if (fall_edge)             fall_seen_reg <= 1'b1;
      else if (ch.frame_arrive)  fall_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_stamp_reg <= `DCSIL_TIME_RST;
      fall_stamp_reg <= `DCSIL_TIME_RST;
    end else begin
      if (rise_edge && (ch.last_edge || !rise_seen_reg))
        rise_stamp_reg <= ch.dc_time; // [R18] [R20] [R21]
      if (fall_edge && (ch.last_edge || !fall_seen_reg))
        fall_stamp_reg <= ch.dc_time; // [R19] [R20] [R21]
    end
  end

  // ---------------------------------------------------------------
  // pending changes, cleared by reading the matching stamp or by an edge of the opposite direction
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_pend_reg <= 1'b0;
      fall_pend_reg <= 1'b0;
    end else begin
      if (rise_edge)                        rise_pend_reg <= 1'b1;
      else if (ch.rise_read || fall_edge)   rise_pend_reg <= 1'b0; // [R17]
      if (fall_edge)                        fall_pend_reg <= 1'b1;
      else if (ch.fall_read || rise_edge)   fall_pend_reg <= 1'b0; // [R17]
    end
  end

  // ---------------------------------------------------------------
  // event byte coding
  // ---------------------------------------------------------------
  always_comb begin
    event_next = `DCSIL_EVT_NONE;
    if (!ch.four_chan) begin
      if (ch.one_shot) begin
        if (fall_pend_reg && !ch.level_in)
          event_next = `DCSIL_EVT2_FALL; // [R15]
        else if (rise_pend_reg || ch.level_in)
          event_next = `DCSIL_EVT2_RISE; // [R15]
      end
    end else if (ch.one_shot) begin
      if (rise_pend_reg)
        event_next = `DCSIL_EVT4_RISE; // [R16]
      else if (ch.level_in)
        event_next = `DCSIL_EVT4_HIGH; // [R16]
    end else if (ch.level_in || rise_pend_reg) begin
      event_next = `DCSIL_EVT4_HIGH; // [R16]
    end
  end

  // level and event byte are frozen on frame arrival
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      event_reg      <= `DCSIL_EVT_NONE;
      level_snap_reg <= 1'b0;
    end else if (ch.frame_arrive) begin
      event_reg      <= event_next; // [R21]
      level_snap_reg <= ch.level_in; // [R13] [R21]
    end
  end

  assign ch.rise_stamp = rise_stamp_reg;
  assign ch.fall_stamp = fall_stamp_reg;
  assign ch.event_byte = event_reg;
  assign ch.level_snap = level_snap_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_evt_reserved: assert property ( // [R14]
    event_reg[7:`DCSIL_EVT_USED_MSB+1] == 5'h00)
    else $error("event byte reserved bits set");

  a_rise_last: assert property ( // [R18]
    rise_edge && ch.last_edge |=> rise_stamp_reg == $past(ch.dc_time))
    else $error("rise stamp not taken on last edge");

  a_fall_first: assert property ( // [R19]
    fall_edge && !fall_seen_reg && !ch.last_edge && !ch.frame_arrive
    ##1 !ch.frame_arrive ##1 fall_edge && !ch.last_edge
    |=> fall_stamp_reg == $past(fall_stamp_reg))
    else $error("fall stamp overwritten in first-edge mode");

  a_read_clears: assert property ( // [R17]
    ch.rise_read && !rise_edge |=> !rise_pend_reg)
    else $error("rise change still shown after stamp read");

  a_free_two: assert property ( // [R15]
    ch.frame_arrive && !ch.one_shot && !ch.four_chan
    |=> event_reg == `DCSIL_EVT_NONE)
    else $error("two-channel free mode event byte not zero");

endmodule : dcsil_edge_chan

// [logic/dcsil_sync_latch.sv]
// sync pulse unit with per-channel edge timestamp latches
`timescale 1ns/1ns
`include "dcsil_map.svh"
// Operation
// [R1] each sync pulse fires at its own target
// [R2] first pulse target shown as next sample time
// [R3] cyclic input sampling starts from sync0
// [R4] master loads first target: now+cycle+shift
// [R5] compare continuously; sample immediately on match
// [R6] advance target by cycle after each pulse
// [R7] master picks period as bus-cycle multiple
// [R8] period is 32-bit nanosecond value
// [R9] shift offsets sync0 in nanosecond steps
// [R10] input shift added when input-reference enabled
// [R11] cyclic enable switches unit; latch mode only
// [R12] sync0 needed; second pulse optional (sync1_pulse here fires without sync0_enable)
// [R13] report level plus latest edge stamps
// [R14] event byte uses bits 0..2 only
// [R15] two-channel event byte coding per mode
// [R16] four-channel event byte coding per mode
// [R17] stamp read clears one-shot change indication
// [R18] rise stamp holds first or last rise
// [R19] fall stamp holds first or last fall
// [R20] stamps are 64-bit local clock times
// [R21] level/event frozen at frame; stamps stay live
// [R22] master should judge short pulses by stamps
module dcsil_sync_latch
  import dcsil_pkg::*;
#(
  parameter int N_CHAN = 2
)
(
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  // configuration
  input  wire logic                         cyclic_enable,
  input  wire logic                         sync0_enable,
  input  wire logic                         sync1_enable,
  input  wire logic                         input_ref_enable,
  input  wire logic                         one_shot_report_mode,
  input  wire logic                         four_chan_variant,
  input  wire logic                         last_edge_mode,
  input  wire logic [`DCSIL_PERIOD_W-1:0]   sync0_cycle_ns,
  input  wire logic [`DCSIL_PERIOD_W-1:0]   local_shift_ns,
  input  wire logic [`DCSIL_PERIOD_W-1:0]   input_shift_ns,
  // master commands
  input  wire logic                         dc_time_load,
  input  wire dcsil_time_type               dc_time_value,
  input  wire logic                         target_arm,
  input  wire dcsil_time_type               target_value,
  input  wire logic                         second_target_load,
  input  wire dcsil_time_type               second_target_value,
  input  wire logic                         frame_arrive,
  input  wire logic [N_CHAN-1:0]            rise_read,
  input  wire logic [N_CHAN-1:0]            fall_read,
  // input pins
  input  wire logic [N_CHAN-1:0]            chan_in,
  // sync unit status
  output dcsil_time_type                    dc_time,
  output logic                              sync0_pulse,
  output logic                              sync1_pulse,
  output logic                              sync_running,
  output dcsil_time_type                    next_sample_time,
  output logic [N_CHAN-1:0]                 sampled_level,
  // channel report
  output logic [N_CHAN-1:0]                 level_snap,
  output dcsil_evt_type  [N_CHAN-1:0]       event_byte,
  output dcsil_time_type [N_CHAN-1:0]       rise_stamp,
  output dcsil_time_type [N_CHAN-1:0]       fall_stamp
);

  // ---------------------------------------------------------------
  // local distributed clock
  // ---------------------------------------------------------------
  dcsil_time_type dc_time_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)            dc_time_reg <= `DCSIL_TIME_RST;
    else if (dc_time_load) dc_time_reg <= dc_time_value;
    else                   dc_time_reg <= dc_time_reg + `DCSIL_DC_STEP_NS;
  end

  assign dc_time = dc_time_reg;

  // ---------------------------------------------------------------
  // sync unit state
  // ---------------------------------------------------------------
  dcsil_state_type state_reg;
  dcsil_state_type state_next;
  logic            unit_on;

  assign unit_on = cyclic_enable && sync0_enable; // [R11] [R12]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DCSIL_SU_OFF: begin
        if (unit_on) state_next = DCSIL_SU_WAIT;
      end
      DCSIL_SU_WAIT: begin
        if (!unit_on)        state_next = DCSIL_SU_OFF;
        else if (target_arm) state_next = DCSIL_SU_RUN;
      end
      DCSIL_SU_RUN: begin
        if (!unit_on) state_next = DCSIL_SU_OFF;
      end
      default: state_next = DCSIL_SU_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) state_reg <= DCSIL_SU_OFF;
    else        state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // first pulse target
  // ---------------------------------------------------------------
  dcsil_time_type target_reg;
  dcsil_time_type shift_total;
  dcsil_time_type cycle_wide;
  logic           sync0_hit;

  assign cycle_wide = {32'h0000_0000, sync0_cycle_ns}; // [R8]
  assign shift_total = {{32{local_shift_ns[31]}}, local_shift_ns} // [R9]
    + (input_ref_enable ? {{32{input_shift_ns[31]}}, input_shift_ns}
                        : `DCSIL_SHIFT_ZERO); // [R10]

  // the clock moves in whole mclk steps, so reaching the target counts
  assign sync0_hit = (state_reg == DCSIL_SU_RUN) && unit_on
                     && (dc_time_reg >= target_reg); // [R1] [R5]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      target_reg <= `DCSIL_TIME_RST;
    else if (target_arm && unit_on)
      target_reg <= target_value + shift_total; // [R4] [R9] [R10]
    else if (sync0_hit)
      target_reg <= target_reg + cycle_wide; // [R6] [R7]
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync0_pulse      <= 1'b0;
      next_sample_time <= `DCSIL_TIME_RST;
      sync_running     <= 1'b0;
    end else begin
      sync0_pulse      <= sync0_hit; // [R1] [R5]
      next_sample_time <= target_reg; // [R2]
      sync_running     <= (state_next == DCSIL_SU_RUN);
    end
  end

  // ---------------------------------------------------------------
  // input sampling on sync0
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)         sampled_level <= '0;
    else if (sync0_hit) sampled_level <= chan_in; // [R3] [R5]
  end

  // ---------------------------------------------------------------
  // second pulse
  // ---------------------------------------------------------------
  dcsil_time_type second_target_reg;
  logic           second_armed_reg;
  logic           sync1_hit;

  assign sync1_hit = cyclic_enable && sync1_enable && second_armed_reg
                     && (dc_time_reg >= second_target_reg); // [R1] [R12]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      second_target_reg <= `DCSIL_TIME_RST;
      second_armed_reg  <= 1'b0;
    end else if (second_target_load) begin
      second_target_reg <= second_target_value;
      second_armed_reg  <= 1'b1;
    end else if (sync1_hit) begin
      second_armed_reg  <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) sync1_pulse <= 1'b0;
    else        sync1_pulse <= sync1_hit; // [R1]
  end

  // ---------------------------------------------------------------
  // per-channel edge latches
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
      dcsil_chan_if chan_if ();
      assign chan_if.level_in     = chan_in[i];
      assign chan_if.dc_time      = dc_time_reg; // [R20]
      assign chan_if.one_shot     = one_shot_report_mode;
      assign chan_if.four_chan    = four_chan_variant;
      assign chan_if.last_edge    = last_edge_mode;
      assign chan_if.frame_arrive = frame_arrive;
      assign chan_if.rise_read    = rise_read[i];
      assign chan_if.fall_read    = fall_read[i];
      dcsil_edge_chan u_chan (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ch    (chan_if.chan)
      );
      assign level_snap[i] = chan_if.level_snap; // [R13]
      assign event_byte[i] = chan_if.event_byte;
      assign rise_stamp[i] = chan_if.rise_stamp;
      assign fall_stamp[i] = chan_if.fall_stamp;
    end
  endgenerate

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence seq_arm;
    target_arm && unit_on && state_reg == DCSIL_SU_WAIT;
  endsequence
  sequence seq_first_fire;
    ##[1:1000] sync0_pulse;
  endsequence

  a_sync0_match: assert property ( // [R5]
    sync0_hit |=> sync0_pulse && sampled_level == $past(chan_in))
    else $error("sync0 match did not pulse and sample");

  a_target_step: assert property ( // [R6]
    sync0_hit && !target_arm
    |=> target_reg == $past(target_reg) + $past(cycle_wide))
    else $error("target not advanced by cycle time");

  a_arm_load: assert property ( // [R10]
    seq_arm |=> target_reg == $past(target_value) + $past(shift_total)
                ##1 next_sample_time == $past(target_reg))
    else $error("armed target or next sample time wrong");

  a_unit_off: assert property ( // [R11]
    !unit_on |=> !sync0_pulse)
    else $error("sync0 fired while unit disabled");

  a_no_early: assert property ( // [R1]
    state_reg == DCSIL_SU_RUN && dc_time_reg < target_reg
    && !dc_time_load |=> !sync0_pulse)
    else $error("sync0 fired before target");

  a_sample_hold: assert property ( // [R3]
    !sync0_hit && !$past(sync0_hit) |=> $stable(sampled_level))
    else $error("inputs sampled without sync0");

  a_sync1_fire: assert property ( // [R12]
    sync1_hit |=> sync1_pulse ##1 !sync1_pulse || $past(second_target_load))
    else $error("second pulse not single");

  a_fire_soon: assert property ( // [R5]
    seq_arm and (target_value + shift_total <= dc_time_reg)
    and (sync0_cycle_ns != 32'h0000_0000)
    |-> (unit_on && !dc_time_load) [*2] |-> seq_first_fire)
    else $error("past target did not fire promptly");

endmodule : dcsil_sync_latch

// [logic/dcsil_fix_note.sv]
// spare design file, holds no logic

// [verification/dcsil_master_model.sv]
// master-side model: time load, sync arming, frames and stamp reads
`timescale 1ns/1ns
module dcsil_master_model
  import dcsil_pkg::*;
(
  // clock and device time
  mclk,
  dc_time,
  // commands to the device
  dc_time_load,
  dc_time_value,
  target_arm,
  target_value,
  second_target_load,
  second_target_value,
  frame_arrive,
  rise_read,
  fall_read
);
  input  wire logic     mclk;
  input  wire dcsil_time_type dc_time;
  output logic           dc_time_load;
  output dcsil_time_type dc_time_value;
  output logic           target_arm;
  output dcsil_time_type target_value;
  output logic           second_target_load;
  output dcsil_time_type second_target_value;
  output logic           frame_arrive;
  output logic [1:0]     rise_read;
  output logic [1:0]     fall_read;

  initial begin
    {dc_time_load, target_arm, second_target_load, frame_arrive} = 4'h0;
    {rise_read, fall_read} = 4'h0;
    {dc_time_value, target_value, second_target_value} = '0;
  end

  // ---------------------------------------------------------------
  // commands, entered just after a falling edge
  // ---------------------------------------------------------------
  task automatic load_time(input dcsil_time_type t0);
    dc_time_load  = 1'b1;
    dc_time_value = t0;
    @(negedge mclk);
    dc_time_load  = 1'b0;
    dc_time_value = ~t0;
  endtask : load_time

  // first target is current time plus cycle, device adds its shift
  task automatic arm(input logic [31:0] cyc);
    target_arm   = 1'b1;
    target_value = dc_time + 64'(cyc);
    @(negedge mclk);
    target_arm   = 1'b0;
    target_value = ~target_value;
  endtask : arm

  task automatic second(input dcsil_time_type t);
    second_target_load  = 1'b1;
    second_target_value = t;
    @(negedge mclk);
    second_target_load  = 1'b0;
    second_target_value = ~t;
  endtask : second

  task automatic frame;
    frame_arrive = 1'b1;
    @(negedge mclk);
    frame_arrive = 1'b0;
  endtask : frame

  // stamps fetched after a frame clear the shown change
  task automatic read(input logic [1:0] r, input logic [1:0] f);
    rise_read = r;
    fall_read = f;
    @(negedge mclk);
    {rise_read, fall_read} = 4'h0;
  endtask : read
endmodule : dcsil_master_model

// [verification/testbench.sv]
// self-checking bench of the sync unit and edge latches
`timescale 1ns/1ns
`include "dcsil_map.svh"
module testbench;
  import dcsil_pkg::*;
  typedef struct packed {dcsil_time_type tgt; logic [1:0] lvl;} dcsil_snote_type;
  typedef struct packed {
    dcsil_evt_type ev; logic [1:0] lvl; dcsil_time_type rs0, fs0, rs1, fs1;
  } dcsil_fnote_type;
  logic                  mclk, rst_b, cyclic_enable, sync0_enable, sync1_enable;
  logic                  input_ref_enable, one_shot, four_chan, last_edge;
  logic [31:0]           cyc, ls, in_sh;
  logic                  dc_time_load, target_arm, second_target_load, frame_arrive;
  dcsil_time_type        dc_time_value, target_value, second_target_value, dc_time;
  dcsil_time_type        next_sample_time, dc_m, tgt, t0;
  logic [1:0]            rise_read, fall_read, chan_in, sampled_level, level_snap;
  logic [1:0]            win_r, win_f;
  logic                  sync0_pulse, sync1_pulse, sync_running, frame_d;
  dcsil_evt_type [1:0]   event_byte;
  dcsil_time_type [1:0]  rise_stamp, fall_stamp, exp_rs, exp_fs;
  dcsil_snote_type       sync_q[$], sn;
  dcsil_fnote_type       frame_q[$], fn;
  dcsil_time_type        s1_q[$];
  dcsil_evt_type         evt_tab [4][4];
  int                    failures, num_checks, seed, i, m;

  dcsil_sync_latch i_dcsil_sync_latch (.mclk(mclk), .rst_b(rst_b),
    .cyclic_enable(cyclic_enable), .sync0_enable(sync0_enable),
    .sync1_enable(sync1_enable), .input_ref_enable(input_ref_enable),
    .one_shot_report_mode(one_shot), .four_chan_variant(four_chan),
    .last_edge_mode(last_edge), .sync0_cycle_ns(cyc), .local_shift_ns(ls),
    .input_shift_ns(in_sh), .dc_time_load(dc_time_load), .dc_time_value(dc_time_value),
    .target_arm(target_arm), .target_value(target_value),
    .second_target_load(second_target_load), .second_target_value(second_target_value),
    .frame_arrive(frame_arrive), .rise_read(rise_read), .fall_read(fall_read),
    .chan_in(chan_in), .dc_time(dc_time), .sync0_pulse(sync0_pulse),
    .sync1_pulse(sync1_pulse), .sync_running(sync_running),
    .next_sample_time(next_sample_time), .sampled_level(sampled_level),
    .level_snap(level_snap), .event_byte(event_byte), .rise_stamp(rise_stamp),
    .fall_stamp(fall_stamp));
  dcsil_master_model i_dcsil_master_model (.mclk(mclk), .dc_time(dc_time),
    .dc_time_load(dc_time_load), .dc_time_value(dc_time_value), .target_arm(target_arm),
    .target_value(target_value), .second_target_load(second_target_load),
    .second_target_value(second_target_value), .frame_arrive(frame_arrive),
    .rise_read(rise_read), .fall_read(fall_read));

  always #5 mclk = ~mclk;

  // local clock model, one step per rising edge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) dc_m <= `DCSIL_TIME_RST;
    else if (dc_time_load) dc_m <= dc_time_value;
    else dc_m <= dc_m + `DCSIL_DC_STEP_NS;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // monitor: results popped against the oldest note
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    frame_d <= frame_arrive;
    if (sync0_pulse === 1'b1) begin
      if (sync_q.size() == 0) check(1'b1, 1'b0);
      else begin
        sn = sync_q.pop_front();
        check(dc_m, sn.tgt + 64'h0000_0000_0000_000A);
        check(next_sample_time, sn.tgt);
        check(sampled_level, sn.lvl);
        check(sync_running, 1'b1);
      end
    end
    if (sync1_pulse === 1'b1) begin
      if (s1_q.size() == 0) check(1'b1, 1'b0);
      else check(dc_m, s1_q.pop_front() + 64'h0000_0000_0000_000A);
    end
    if (frame_d && frame_q.size() != 0) begin
      fn = frame_q.pop_front();
      check(event_byte[0], fn.ev);
      check(level_snap, fn.lvl);
      check(rise_stamp[0], fn.rs0);
      check(fall_stamp[0], fn.fs0);
      check(rise_stamp[1], fn.rs1);
      check(fall_stamp[1], fn.fs1);
    end
  end

  // edge on a channel, with first or last stamp kept per frame window
  task automatic set_edge(input int ch, input logic v);
    if (chan_in[ch] !== v) begin
      chan_in[ch] = v;
      if (v && (last_edge || !win_r[ch])) exp_rs[ch] = dc_m;
      if (!v && (last_edge || !win_f[ch])) exp_fs[ch] = dc_m;
      if (v) win_r[ch] = 1'b1;
      else win_f[ch] = 1'b1;
    end
  endtask : set_edge

  task automatic do_frame(input dcsil_evt_type ev);
    frame_q.push_back('{ev, chan_in, exp_rs[0], exp_fs[0], exp_rs[1], exp_fs[1]});
    win_r = 2'b00;
    win_f = 2'b00;
    i_dcsil_master_model.frame();
  endtask : do_frame

  initial begin
    #500_000;
    failures++;
    end_of_test();
  end

  initial begin
    seed = 25330;
    mclk = 1'b0;
    rst_b = 1'b0;
    {cyclic_enable, sync0_enable, sync1_enable, input_ref_enable} = 4'h0;
    {one_shot, four_chan, last_edge} = 3'h0;
    {win_r, win_f, exp_rs, exp_fs} = '0;
    evt_tab = '{'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h01, 8'h02, 8'h00},
                '{8'h04, 8'h04, 8'h00, 8'h00}, '{8'h05, 8'h04, 8'h00, 8'h00}};
    cyc = 32'h0000_00C8 + ({$random(seed)} % 41) * 32'h0000_000A;
    ls = ({$random(seed)} % 50) * 32'h0000_000A;
    in_sh = ({$random(seed)} % 50) * 32'h0000_000A;
    chan_in = 2'($random(seed));
    t0 = {1'b0, 31'($random(seed)), 32'($random(seed))};
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    i_dcsil_master_model.load_time(t0);
    i_dcsil_master_model.arm(cyc);
    repeat (80) @(negedge mclk);
    input_ref_enable = 1'b1;
    {cyclic_enable, sync0_enable, sync1_enable} = 3'h7;
    repeat (2) @(negedge mclk);
    tgt = dc_m + 64'(cyc) + 64'(ls) + 64'(in_sh);
    for (i = 0; i < 4; i++) sync_q.push_back('{tgt + 64'(i) * 64'(cyc), chan_in});
    i_dcsil_master_model.arm(cyc);
    s1_q.push_back(dc_m + 64'h0000_0000_0000_00C8);
    i_dcsil_master_model.second(dc_m + 64'h0000_0000_0000_00C8);
    for (i = 0; i < 1000 && sync_q.size() != 0; i++) @(negedge mclk);
    cyclic_enable = 1'b0;
    repeat (3) @(negedge mclk);
    check(sync_q.size() + s1_q.size(), 0);
    check(sync_running, 1'b0);
    for (m = 0; m < 4; m++) begin
      one_shot = m[0];
      four_chan = m[1];
      last_edge = m[0] ^ m[1];
      set_edge(0, 1'b0);
      set_edge(1, 1'b0);
      repeat (2) @(negedge mclk);
      i_dcsil_master_model.read(2'b11, 2'b11);
      do_frame(`DCSIL_EVT_NONE);
      set_edge(1, 1'b1);
      @(negedge mclk);
      set_edge(1, 1'b0);
      @(negedge mclk);
      set_edge(1, 1'b1);
      set_edge(0, 1'b1);
      @(negedge mclk);
      do_frame(evt_tab[m][0]);
      i_dcsil_master_model.read(2'b01, 2'b00);
      do_frame(evt_tab[m][1]);
      set_edge(0, 1'b0);
      set_edge(1, 1'b0);
      @(negedge mclk);
      do_frame(evt_tab[m][2]);
      i_dcsil_master_model.read(2'b00, 2'b01);
      do_frame(evt_tab[m][3]);
    end
    repeat (3) @(negedge mclk);
    end_of_test();
  end
endmodule : testbench
